// ---- logic/hlpf_framer.sv ----
// Purpose: trigger primitive framer for a two-plane hodoscope, plus its output FIFO
// Assumes: hits arrive in time order; mclk 200 MHz; sys_rst synchronous active high
// Notes: Summary of operation list below
// Summary of operation
// - each primitive leaves as one 8-byte frame
// - fine-time field is exactly eight bits
// - upper five bits: sub-window index of 32
// - lower three bits: hit count, saturating at four
// - adjacent sub-windows give separate frames
// - optional packing sends detector id once
// - subtract per-channel offset from look-up table
// - hits of both planes combined online
// - slewing and propagation correction applied per hit
// - accepts hits from 128 channels, two planes
// - coarse timestamp takes four frame bytes
`timescale 1ns/1ps

module hlpf_fifo
	import hlpf_pkg::*;
#(
	parameter int WIDTH = 64,
	parameter int DEPTH = 16,
	parameter int CNT_W = 5
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [CNT_W-1:0] count
);
	localparam int PTR_W = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic push;
	logic pop;

	// handshake terms, honest full and empty
	assign in_ready = (count != CNT_W'(DEPTH));
	assign out_valid = (count != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	// storage write
	always_ff @(posedge mclk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// pointers and occupancy
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule

module hlpf_framer
	import hlpf_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// hit input from the converter boards
	input wire logic hit_valid,
	output logic hit_ready,
	input wire hlpf_hit_type hit,
	// offset look-up table load
	input wire logic lut_wr,
	input wire logic [CHAN_W-1:0] lut_channel,
	input wire logic [OFFSET_W-1:0] lut_offset,
	// configuration
	input wire logic [DET_ID_W-1:0] det_id,
	input wire logic pack_en,
	// frame stream toward the trigger unit link
	output logic frame_valid,
	input wire logic frame_ready,
	output logic [FRAME_W-1:0] frame_data,
	output logic frame_last
);
	logic [OFFSET_W-1:0] offset_lut [NUM_CHANNELS];
	logic s1_valid;
	logic [TIME_W-1:0] s1_time;
	logic s1_plane;
	hlpf_acc_type acc_state;
	logic [TIME_W-1:0] acc_time;
	logic [MULT_W-1:0] acc_mult;
	logic [PLANE_MASK_W-1:0] acc_planes;
	logic [FLUSH_W-1:0] idle_cnt;
	logic [DET_ID_W-1:0] det_id_q;
	logic emit;
	hlpf_frame_type emit_frame;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [FRAME_W-1:0] fifo_out_data;
	logic [FIFO_CNT_W-1:0] fifo_count;
	logic [PACK_CNT_W-1:0] pack_cnt;
	logic new_window;
	logic load_out;

	// offset table, written by the loader port
	always_ff @(posedge mclk)
	begin
		if (lut_wr)
			offset_lut[lut_channel] <= lut_offset;
	end

	// detector id held stable for framing
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			det_id_q <= DET_ID_RESET;
		else
			det_id_q <= det_id;
	end

	// accept only while the buffer has room for in-flight frames
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			hit_ready <= 1'b0;
		else
			hit_ready <= (fifo_count <= FIFO_CNT_W'(FIFO_DEPTH) - FIFO_HEADROOM);
	end

	// align stage: subtract channel offset and per-hit correction
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			s1_valid <= 1'b0;
			s1_time <= '0;
			s1_plane <= 1'b0;
		end
		else
		begin
			s1_valid <= hit_valid && hit_ready;
			s1_time <= hit.time_raw - TIME_W'(offset_lut[hit.channel]) - TIME_W'(hit.corr);
			s1_plane <= hit.channel[PLANE_BIT];
		end
	end

	// a hit in another sub-window, even the next one, closes the open window
	assign new_window = s1_valid && (acc_state == ACC_OPEN) && (s1_time != acc_time);
	assign emit = new_window || ((acc_state == ACC_OPEN) && !s1_valid && idle_cnt == FLUSH_W'(FLUSH_CYCLES));

	// frame assembly from the open window
	always_comb
	begin
		emit_frame.det_id = det_id_q;
		emit_frame.plane_mask = acc_planes;
		emit_frame.timestamp = acc_time[TIME_W-1:SUB_W];
		emit_frame.sub_window = acc_time[SUB_W-1:0];
		emit_frame.mult = acc_mult;
	end

	// window accumulator: counts hits of both planes per sub-window
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			acc_state <= ACC_IDLE;
			acc_time <= '0;
			acc_mult <= '0;
			acc_planes <= '0;
			idle_cnt <= '0;
		end
		else
		begin
			case (acc_state)
				ACC_IDLE:
				begin
					idle_cnt <= '0;
					if (s1_valid)
					begin
						acc_state <= ACC_OPEN;
						acc_time <= s1_time;
						acc_mult <= 3'h1;
						acc_planes <= PLANE_MASK_W'(1) << s1_plane;
					end
				end
				ACC_OPEN:
				begin
					if (s1_valid)
					begin
						idle_cnt <= '0;
						if (new_window)
						begin
							acc_time <= s1_time;
							acc_mult <= 3'h1;
							acc_planes <= PLANE_MASK_W'(1) << s1_plane;
						end
						else
						begin
							if (acc_mult != MULT_SAT)
								acc_mult <= acc_mult + 1'b1;
							acc_planes <= acc_planes | (PLANE_MASK_W'(1) << s1_plane);
						end
					end
					else if (emit)
						acc_state <= ACC_IDLE;
					// a hit held back by our own back-pressure freezes the flush timer,
					// so a stalled window is not split into two frames
					else if (!hit_valid)
						idle_cnt <= idle_cnt + 1'b1;
				end
				default:
					acc_state <= ACC_IDLE;
			endcase
		end
	end

	// output buffer of frames
	hlpf_fifo #(
		.WIDTH(FRAME_W),
		.DEPTH(FIFO_DEPTH),
		.CNT_W(FIFO_CNT_W)
	) u_fifo (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.in_valid(emit),
		.in_ready(fifo_in_ready),
		.in_data(emit_frame),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data),
		.count(fifo_count)
	);

	assign load_out = !frame_valid || frame_ready;
	assign fifo_pop = load_out && fifo_out_valid;

	// registered output stage with optional packing of frames
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			frame_valid <= 1'b0;
			frame_data <= '0;
			frame_last <= 1'b0;
			pack_cnt <= '0;
		end
		else if (load_out)
		begin
			frame_valid <= fifo_out_valid;
			if (fifo_out_valid)
			begin
				frame_data <= fifo_out_data;
				if (pack_en && pack_cnt != '0)
					frame_data[FRAME_W-1 -: DET_ID_W] <= '0;
				if (!pack_en || pack_cnt == PACK_MAX - 1'b1 || fifo_count == FIFO_CNT_W'(1))
				begin
					frame_last <= 1'b1;
					pack_cnt <= '0;
				end
				else
				begin
					frame_last <= 1'b0;
					pack_cnt <= pack_cnt + 1'b1;
				end
			end
		end
	end
endmodule

// ---- logic/hlpf_pkg.sv ----
// Purpose: shared constants and carrier types for the hodoscope trigger primitive framer
// Assumes: 200 MHz mclk, synchronous active-high reset
// Notes: frame layout is fixed here and must match the trigger unit's decoder
package hlpf_pkg;
	// clock and timing
	localparam int CLK_MHZ = 200;
	localparam int FLUSH_NS = 200;
	localparam int FLUSH_CYCLES = (FLUSH_NS * CLK_MHZ + 999) / 1000;
	localparam int FLUSH_W = 8;

	// detector geometry
	localparam int NUM_CHANNELS = 128;
	localparam int CHAN_W = 7;
	localparam int PLANE_BIT = 6;

	// hit time: coarse 25 ns count plus fine index of 32 sub-windows
	localparam int COARSE_W = 32;
	localparam int SUB_W = 5;
	localparam int TIME_W = COARSE_W + SUB_W;
	localparam int OFFSET_W = 12;
	localparam int CORR_W = 8;

	// fine-time field: sub-window index above, hit count below
	localparam int FINE_W = 8;
	localparam int MULT_W = 3;
	localparam logic [MULT_W-1:0] MULT_SAT = 3'h4;

	// frame layout, 8 bytes
	localparam int FRAME_BYTES = 8;
	localparam int FRAME_W = FRAME_BYTES * 8;
	localparam int DET_ID_W = 16;
	localparam int PLANE_MASK_W = 8;
	localparam logic [DET_ID_W-1:0] DET_ID_RESET = 16'h0001;

	// output buffering and packing
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_CNT_W = 5;
	localparam logic [FIFO_CNT_W-1:0] FIFO_HEADROOM = 5'h04;
	localparam int PACK_CNT_W = 4;
	localparam logic [PACK_CNT_W-1:0] PACK_MAX = 4'h8;

	typedef struct packed {
		logic [CHAN_W-1:0] channel;
		logic [TIME_W-1:0] time_raw;
		logic [CORR_W-1:0] corr;
	} hlpf_hit_type;

	typedef struct packed {
		logic [DET_ID_W-1:0] det_id;
		logic [PLANE_MASK_W-1:0] plane_mask;
		logic [COARSE_W-1:0] timestamp;
		logic [SUB_W-1:0] sub_window;
		logic [MULT_W-1:0] mult;
	} hlpf_frame_type;

	typedef enum logic [1:0] {
		ACC_IDLE = 2'b01,
		ACC_OPEN = 2'b10
	} hlpf_acc_type;
endpackage

// ---- test/hlpf_framer_asserts.sv ----
// Purpose: port checks of the framer stream
// Assumes: one mclk domain
// Notes: bound to hlpf_framer
`timescale 1ns/1ps
module hlpf_framer_asserts
	import hlpf_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// config and hit side
	input wire logic [DET_ID_W-1:0] det_id,
	input wire logic pack_en,
	input wire logic hit_ready,
	// frame side
	input wire logic frame_valid,
	input wire logic frame_ready,
	input wire logic [FRAME_W-1:0] frame_data,
	input wire logic frame_last
);
	// one domain, reset masks all
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_reset_quiet: assert property ($past(sys_rst) |-> !frame_valid && !hit_ready)
		else $error("busy after reset");
	a_hold_stall: assert property (frame_valid && !frame_ready |=> frame_valid && $stable(frame_data) && $stable(frame_last))
		else $error("frame changed in stall");
	a_mult_range: assert property (frame_valid |-> frame_data[2:0] inside {[3'h1:3'h4]})
		else $error("bad count");
	a_plane_mask: assert property (frame_valid |-> frame_data[47:42] == 6'h00 && frame_data[41:40] != 2'h0)
		else $error("bad plane mask");
	a_last_single: assert property (frame_valid && !pack_en |-> frame_last)
		else $error("last missing");
	a_detid_single: assert property (frame_valid && !pack_en |-> frame_data[63:48] == det_id)
		else $error("bad id");
	a_pack_chain: assert property (frame_valid && frame_ready && pack_en && !frame_last |=> frame_valid && frame_data[63:48] == 16'h0000)
		else $error("broken packet");
	a_new_window: assert property (frame_valid && frame_ready |=> !frame_valid || frame_data[39:3] != $past(frame_data[39:3]))
		else $error("window repeated");
endmodule
bind hlpf_framer hlpf_framer_asserts u_chk (.mclk(mclk), .sys_rst(sys_rst), .det_id(det_id), .pack_en(pack_en),
	.hit_ready(hit_ready), .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_data(frame_data), .frame_last(frame_last));

// ---- test/hlpf_sink.sv ----
// Purpose: trigger unit stand-in
// Assumes: ready moves at falling mclk
// Notes: slow takes every other cycle
`timescale 1ns/1ps
module hlpf_sink
	import hlpf_pkg::*;
(
	// clock
	input wire logic mclk,
	// behaviour
	input wire logic stall,
	input wire logic slow,
	// handshake
	output logic frame_ready = 1'b0
);
	logic phase = 1'b0;
	// ready pattern
	always @(negedge mclk)
	begin
		phase <= !phase;
		frame_ready <= !stall && (!slow || phase);
	end
endmodule

// ---- test/testbench.sv ----
// Purpose: self-checking framer bench
// Assumes: frames checked in order
// Notes: inputs move at falling mclk
`timescale 1ns/1ps
module testbench
	import hlpf_pkg::*;
;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic hit_valid = 1'b0;
	hlpf_hit_type hit = '0;
	logic lut_wr = 1'b0;
	logic [CHAN_W-1:0] lut_channel = 7'h05;
	logic [OFFSET_W-1:0] lut_offset = 12'h123;
	logic [DET_ID_W-1:0] det_id = 16'h0001;
	logic pack_en = 1'b0;
	logic stall = 1'b1;
	logic slow = 1'b0;
	logic refused = 1'b0;
	logic hit_ready, frame_valid, frame_ready, frame_last;
	logic [FRAME_W-1:0] frame_data;
	logic [FRAME_W:0] exp_q[$];
	int error_cnt = 0;
	int checks = 0;
	localparam logic [36:0] BASE = 37'h0abcdef00;
	// 200 MHz clock
	always #2.5 mclk = !mclk;
	hlpf_framer u_dut (.mclk(mclk), .sys_rst(sys_rst), .hit_valid(hit_valid), .hit_ready(hit_ready), .hit(hit),
		.lut_wr(lut_wr), .lut_channel(lut_channel), .lut_offset(lut_offset), .det_id(det_id), .pack_en(pack_en),
		.frame_valid(frame_valid), .frame_ready(frame_ready), .frame_data(frame_data), .frame_last(frame_last));
	hlpf_sink u_sink (.mclk(mclk), .stall(stall), .slow(slow), .frame_ready(frame_ready));
	task chk(input string name, input logic [FRAME_W:0] seen, input logic [FRAME_W:0] want);
		checks++;
		if (seen !== want)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", name, want, seen);
		end
	endtask
	// each taken frame against the oldest expectation
	always @(posedge mclk)
		if (frame_valid === 1'b1 && frame_ready === 1'b1)
			chk("frame", {frame_last, frame_data}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
	// hit time before offset and correction are removed
	function automatic logic [36:0] raw(input logic [6:0] c, input logic [36:0] a);
		raw = a + 37'(c[6] ? 12'h0a7 : 12'h123) + 37'h10;
	endfunction
	task send(input logic [6:0] c, input logic [36:0] a);
		int n;
		@(negedge mclk);
		hit_valid = 1'b1;
		hit = '{channel: c, time_raw: raw(c, a), corr: 8'h10};
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
			if (n == 80)
			begin
				refused = 1'b1;
				stall = 1'b0;
			end
		end
		while (hit_ready !== 1'b1);
	endtask
	task drain(input string name);
		int n;
		@(negedge mclk);
		hit_valid = 1'b0;
		repeat (60) @(negedge mclk);
		stall <= 1'b0;
		for (n = 0; n < 500 && exp_q.size() > 0; n++)
			@(negedge mclk);
		chk("left", 65'(exp_q.size()), 65'h0);
		$display("test %s done", name);
	endtask
	// adjacent windows, counts 1 to 5, both planes, buffer filled until hit_ready drops
	task t_burst;
		logic [36:0] a;
		@(negedge mclk);
		det_id = 16'h5a3c;
		for (int w = 0; w < 17; w++)
		begin
			a = BASE + 37'(w);
			for (int j = 0; j <= w % 5; j++)
				send(j[0] ? 7'h45 : 7'h05, a);
			exp_q.push_back({1'b1, 16'h5a3c, w % 5 ? 8'h03 : 8'h01, a, w % 5 == 4 ? 3'h4 : 3'(w % 5 + 1)});
		end
		drain("burst");
		chk("refused", 65'(refused), 65'h1);
	endtask
	// packed run of three spaced windows, slow drain; the first frame finds the
	// output stage empty and the buffer holding only itself, so it goes alone;
	// the other two wait behind it and leave as one packet of two
	task t_pack;
		@(negedge mclk);
		pack_en = 1'b1;
		stall <= 1'b1;
		slow <= 1'b1;
		for (int w = 0; w < 3; w++)
		begin
			send(7'h45, BASE + 37'(64 + 2 * w));
			exp_q.push_back({w != 1, w != 2 ? 16'h5a3c : 16'h0000, 8'h02, BASE + 37'(64 + 2 * w), 3'h1});
		end
		drain("pack");
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// watchdog
	initial
	begin
		repeat (20000) @(posedge mclk);
		error_cnt++;
		give_verdict();
	end
	// reset, offset table, tests
	initial
	begin
		repeat (4) @(negedge mclk);
		sys_rst = 1'b0;
		lut_wr = 1'b1;
		@(negedge mclk);
		lut_channel = 7'h45;
		lut_offset = 12'h0a7;
		@(negedge mclk);
		lut_wr = 1'b0;
		t_burst();
		t_pack();
		give_verdict();
	end
endmodule
